/* core/analog_sample_sequencer.sv */
// Sequencer, timer, register file and threshold check for the four-channel converter.
`timescale 1ns/10ps
`default_nettype none
module analog_sample_sequencer #(
    parameter int AUTO_BASE_CYCLES = analog_seq_pkg::AUTO_BASE_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register access from the message engine
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Read-all request and its completion
    input wire logic readAllReq,
    output logic readAllDone,
    // Scheduled auto conversion enable
    input wire logic autoModeEnable,
    // Change message request
    output logic changeMsgReq,
    // Converter core
    output logic converterPowerOn,
    output logic [1:0] conversionClockSelect,
    output logic [1:0] referenceSelect,
    output logic [3:0] pinAnalogSelect,
    output logic convStart,
    output logic [1:0] convChannel,
    input wire logic convDone,
    input wire logic [9:0] convResult
);

    typedef struct packed {
        analog_seq_pkg::seq_state_t state;
        analog_seq_pkg::seq_kind_t kind;
        logic [3:0] mask;
        logic [3:0] seqSet;
        logic [1:0] chan;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] txcEn;
        logic [3:0][7:0] thrHi;
        logic [3:0][1:0] thrLo;
        logic [3:0] pol;
        logic [3:0][9:0] result;
        logic [3:0][1:0] lowLatch;
        logic [analog_seq_pkg::PRESCALE_WIDTH-1:0] prescale;
        logic autoPending;
        logic allPending;
        logic singlePending;
        logic [1:0] singleChan;
        logic [7:0] rdData;
        logic rdValid;
        logic start;
        logic allDone;
        logic changeReq;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] lowestSet(input logic [3:0] m);
        return m[0] ? 2'd0 : (m[1] ? 2'd1 : (m[2] ? 2'd2 : 2'd3));
    endfunction : lowestSet

    function automatic logic [3:0] prescaleShift(input logic [2:0] code);
        logic [3:0] sh;
        case (code)
            3'h0: sh = 4'h0;
            3'h1: sh = 4'h3;
            3'h2: sh = 4'h5;
            3'h3: sh = 4'h7;
            3'h4: sh = 4'h9;
            3'h5: sh = 4'ha;
            3'h6: sh = 4'hb;
            default: sh = 4'hc;
        endcase
        return sh;
    endfunction : prescaleShift

    // True when a channel's result crosses its threshold in the chosen direction.
    function automatic logic crossed(input logic [9:0] r, input logic [9:0] t, input logic above);
        return above ? (r > t) : (r < t);
    endfunction : crossed

    logic powerOn;
    logic [3:0] analogMask;
    logic timerRun;
    logic [analog_seq_pkg::PRESCALE_WIDTH-1:0] intervalLimit;
    logic [1:0] regChan;
    logic [1:0] thrChan;

    assign powerOn = s.ctrl0[analog_seq_pkg::POWER_ON_BIT];
    assign analogMask = ~s.ctrl1[analog_seq_pkg::PIN_CONFIG_MSB:analog_seq_pkg::PIN_CONFIG_LSB];
    assign timerRun = powerOn && autoModeEnable && (|(analogMask & s.txcEn[3:0]));
    assign intervalLimit = analog_seq_pkg::PRESCALE_WIDTH'((AUTO_BASE_CYCLES
        << prescaleShift(s.ctrl0[analog_seq_pkg::PRESCALE_MSB:analog_seq_pkg::PRESCALE_LSB])) - 1);
    assign regChan = 2'((regAddr - analog_seq_pkg::ADDR_RESULT_BASE) >> 1);
    // Threshold pairs are laid out from channel 3 down to channel 0.
    assign thrChan = 2'd3 - 2'((regAddr - analog_seq_pkg::ADDR_THRESHOLD_BASE) >> 1);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [3:0] remaining;
        logic hit;
        logic tick;
        remaining = 4'h0;
        hit = 1'b0;
        tick = 1'b0;
        next_s = s;
        next_s.rdValid = 1'b0;
        next_s.start = 1'b0;
        next_s.allDone = 1'b0;
        next_s.changeReq = 1'b0;

        // Interval timer; held at zero while idle so each run starts a full period.
        if (!timerRun)
            next_s.prescale = '0;
        else if (s.prescale >= intervalLimit)
        begin
            next_s.prescale = '0;
            next_s.autoPending = 1'b1;
            tick = 1'b1;
        end
        else
            next_s.prescale = s.prescale + 1'b1;

        if (readAllReq)
        begin
            next_s.allPending = 1'b1;
        end

        // Register writes.
        if (regWrEn)
        begin
            if (regAddr == analog_seq_pkg::ADDR_POWER_RATE_CONTROL)
                next_s.ctrl0 = regWrData & analog_seq_pkg::POWER_RATE_WRITE_MASK;
            else if (regAddr == analog_seq_pkg::ADDR_CLOCK_REF_PIN_CONFIG)
                next_s.ctrl1 = regWrData;
            else if (regAddr == analog_seq_pkg::ADDR_CHANGE_TRANSMIT_ENABLE)
                next_s.txcEn = regWrData;
            else if (regAddr >= analog_seq_pkg::ADDR_THRESHOLD_BASE && regAddr <= analog_seq_pkg::ADDR_THRESHOLD_LAST)
            begin
                if (!regAddr[0])
                begin
                    next_s.thrHi[thrChan] = regWrData;
                end
                else
                begin
                    next_s.thrLo[thrChan] = regWrData[7:6];
                    next_s.pol[thrChan] = regWrData[analog_seq_pkg::POLARITY_BIT];
                end
            end
        end

        // Register reads; an upper result read may start a conversion instead.
        if (regRdEn)
        begin
            next_s.rdValid = 1'b1;
            next_s.rdData = 8'h00;
            if (regAddr == analog_seq_pkg::ADDR_POWER_RATE_CONTROL)
                next_s.rdData = s.ctrl0;
            else if (regAddr == analog_seq_pkg::ADDR_CLOCK_REF_PIN_CONFIG)
                next_s.rdData = s.ctrl1;
            else if (regAddr == analog_seq_pkg::ADDR_CHANGE_TRANSMIT_ENABLE)
                next_s.rdData = s.txcEn;
            else if (regAddr >= analog_seq_pkg::ADDR_THRESHOLD_BASE && regAddr <= analog_seq_pkg::ADDR_THRESHOLD_LAST)
            begin
                next_s.rdData = regAddr[0] ? {s.thrLo[thrChan], 5'h00, s.pol[thrChan]} : s.thrHi[thrChan];
            end
            else if (regAddr >= analog_seq_pkg::ADDR_RESULT_BASE && regAddr <= analog_seq_pkg::ADDR_RESULT_LAST)
            begin
                if (regAddr[0])
                begin
                    next_s.rdData = {s.lowLatch[regChan], 6'h00};
                end
                else if (powerOn && analogMask[regChan])
                begin
                    next_s.rdValid = 1'b0;
                    next_s.singlePending = 1'b1;
                    next_s.singleChan = regChan;
                end
                else
                begin
                    next_s.rdData = s.result[regChan][9:2];
                    next_s.lowLatch[regChan] = s.result[regChan][1:0];
                end
            end
        end

        // Sequencer.
        case (s.state)
            analog_seq_pkg::ST_IDLE:
            begin
                if (powerOn && s.singlePending)
                begin
                    next_s.singlePending = 1'b0;
                    next_s.kind = analog_seq_pkg::KIND_SINGLE;
                    next_s.mask = 4'h1 << s.singleChan;
                    next_s.state = analog_seq_pkg::ST_START;
                end
                else if (powerOn && s.allPending)
                begin
                    next_s.allPending = readAllReq;
                    if (analogMask == 4'h0)
                    begin
                        next_s.allDone = 1'b1;
                    end
                    else
                    begin
                        next_s.kind = analog_seq_pkg::KIND_ALL;
                        next_s.mask = analogMask;
                        next_s.state = analog_seq_pkg::ST_START;
                    end
                end
                else if (powerOn && s.autoPending)
                begin
                    next_s.autoPending = tick;
                    if ((analogMask & s.txcEn[3:0]) != 4'h0)
                    begin
                        next_s.kind = analog_seq_pkg::KIND_AUTO;
                        next_s.mask = analogMask & s.txcEn[3:0];
                        next_s.seqSet = analogMask & s.txcEn[3:0];
                        next_s.state = analog_seq_pkg::ST_START;
                    end
                end
            end
            analog_seq_pkg::ST_START:
            begin
                next_s.chan = lowestSet(s.mask);
                next_s.start = 1'b1;
                next_s.state = analog_seq_pkg::ST_WAIT;
            end
            analog_seq_pkg::ST_WAIT:
            begin
                if (convDone)
                begin
                    remaining = s.mask & ~(4'h1 << s.chan);
                    next_s.mask = remaining;
                    next_s.result[s.chan] = convResult;
                    if (s.kind != analog_seq_pkg::KIND_AUTO)
                    begin
                        next_s.lowLatch[s.chan] = convResult[1:0];
                    end
                    if (s.kind == analog_seq_pkg::KIND_SINGLE)
                    begin
                        next_s.rdData = convResult[9:2];
                        next_s.rdValid = 1'b1;
                    end
                    if (remaining != 4'h0)
                    begin
                        next_s.state = analog_seq_pkg::ST_START;
                    end
                    else
                    begin
                        next_s.state = analog_seq_pkg::ST_IDLE;
                        next_s.kind = analog_seq_pkg::KIND_NONE;
                        next_s.allDone = (s.kind == analog_seq_pkg::KIND_ALL);
                        if (s.kind == analog_seq_pkg::KIND_AUTO)
                        begin
                            for (int c = 0; c < 4; c++)
                            begin
                                if (s.seqSet[c] && crossed(next_s.result[c], {s.thrHi[c], s.thrLo[c]}, s.pol[c]))
                                begin
                                    hit = 1'b1;
                                end
                            end
                            next_s.changeReq = hit;
                        end
                    end
                end
            end
            default:
            begin
                next_s.state = analog_seq_pkg::ST_IDLE;
            end
        endcase

        // Switching off (the value being written counts) abandons the sequence; waiting requesters get stored values.
        if (!next_s.ctrl0[analog_seq_pkg::POWER_ON_BIT])
        begin
            if (!next_s.rdValid && (next_s.singlePending || next_s.kind == analog_seq_pkg::KIND_SINGLE))
            begin
                next_s.rdData = s.result[next_s.singleChan][9:2];
                next_s.rdValid = 1'b1;
            end
            if (next_s.allPending || next_s.kind == analog_seq_pkg::KIND_ALL)
            begin
                next_s.allDone = 1'b1;
            end
            next_s.singlePending = 1'b0;
            next_s.allPending = 1'b0;
            next_s.autoPending = 1'b0;
            next_s.state = analog_seq_pkg::ST_IDLE;
            next_s.kind = analog_seq_pkg::KIND_NONE;
            next_s.mask = 4'h0;
            next_s.start = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            s <= '0;
        else
            s <= next_s;
    end

    assign regRdData = s.rdData;
    assign regRdValid = s.rdValid;
    assign readAllDone = s.allDone;
    assign changeMsgReq = s.changeReq;
    assign converterPowerOn = powerOn;
    assign conversionClockSelect = s.ctrl1[analog_seq_pkg::CLOCK_SELECT_MSB:analog_seq_pkg::CLOCK_SELECT_LSB];
    assign referenceSelect = s.ctrl1[analog_seq_pkg::REFERENCE_MSB:analog_seq_pkg::REFERENCE_LSB];
    assign pinAnalogSelect = s.ctrl1[analog_seq_pkg::PIN_CONFIG_MSB:analog_seq_pkg::PIN_CONFIG_LSB];
    assign convStart = s.start;
    assign convChannel = s.chan;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_start_powered: assert property (@(posedge clk) disable iff (reset)
        convStart |-> converterPowerOn) else $error("conversion started while off");
    a_start_analog: assert property (@(posedge clk) disable iff (reset)
        convStart |-> !pinAnalogSelect[convChannel]) else $error("digital pin converted");
    a_start_cause: assert property (@(posedge clk) disable iff (reset)
        convStart |-> s.kind != analog_seq_pkg::KIND_NONE) else $error("unrequested conversion");
    a_channel_order: assert property (@(posedge clk) disable iff (reset)
        convStart |-> (s.mask & ((4'h1 << convChannel) - 4'h1)) == 4'h0) else $error("channel out of order");
    a_result_store: assert property (@(posedge clk) disable iff (reset)
        s.state == analog_seq_pkg::ST_WAIT && convDone && converterPowerOn
        |=> s.result[$past(convChannel)] == $past(convResult)) else $error("result not stored");
    a_timer_idle: assert property (@(posedge clk) disable iff (reset)
        !timerRun |=> s.prescale == '0) else $error("timer ran while disabled");
    a_reset_clear: assert property (@(posedge clk)
        reset |=> s.prescale == '0 && !convStart) else $error("prescaler not cleared");
    a_read_all_order: assert property (@(posedge clk) disable iff (reset)
        readAllDone && converterPowerOn |-> s.mask == 4'h0) else $error("reply before conversions");
    a_change_single: assert property (@(posedge clk) disable iff (reset)
        changeMsgReq |=> !changeMsgReq) else $error("change message repeated");
    a_upper_answer: assert property (@(posedge clk) disable iff (reset)
        s.state == analog_seq_pkg::ST_WAIT && convDone && s.kind == analog_seq_pkg::KIND_SINGLE && converterPowerOn
        |=> regRdValid && regRdData == $past(convResult[9:2])) else $error("upper byte answer wrong");

endmodule : analog_sample_sequencer
`default_nettype wire

/* core/analog_seq_pkg.sv */
// Constants, types and register map for the analog sample sequencer.
// What this block does
// - Auto mode converts enabled analog channels in turn, channel zero first, upward.
// - A finished conversion is stored in that channel's own result registers.
// - Auto interval is oscillator period times 1024 times the prescale ratio.
// - Control zero bits 6-4 pick ratio 1, 8, 32, 128, 512, 1024, 2048, 4096.
// - Interval timer runs only while an analog pin has change transmit enabled.
// - Prescaler counter is cleared by any device reset.
// - On-request channels convert only after a read-all or read-register request.
// - While powered on, a read-all request converts every analog pin before the reply is released.
// - While powered on, reading an analog channel's upper result byte converts it then and returns that byte.
// - Lower byte read returns bits latched at the last upper or read-all request, no new conversion.
// - After auto conversion, below or above threshold per polarity sends change message.
// - Low four bits of the change transmit enable register gate each channel's detection.
// - Several channels hitting together give one message carrying all channels.
// - Results readable through upper and lower result registers and read-all reply.
// - Upper result holds bits 9-2; lower holds bits 1-0 in 7-6, rest zero.
// - Threshold split likewise: upper holds bits 9-2, lower holds bits 1-0 in 7-6.
// - Control zero bit 7 switches the converter on; zero shuts it off.
// - Control one bits 7-6 select conversion clock divide 2, 8, 32; 11 reserved.
// - Control one bits 5-4 select the reference pair.
// - Control one bits 3-0 make each pin digital when one, analog when zero.
package analog_seq_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CHANGE_TRANSMIT_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_POWER_RATE_CONTROL = 8'h0e;
    localparam logic [7:0] ADDR_CLOCK_REF_PIN_CONFIG = 8'h0f;
    // Threshold pairs run downward: channel 3 upper at 2Ch, channel 0 lower at 33h.
    localparam logic [7:0] ADDR_THRESHOLD_BASE = 8'h2c;
    localparam logic [7:0] ADDR_THRESHOLD_LAST = 8'h33;
    // Result pairs: channel n upper at base + 2n, lower at base + 2n + 1.
    localparam logic [7:0] ADDR_RESULT_BASE = 8'h50;
    localparam logic [7:0] ADDR_RESULT_LAST = 8'h57;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int POWER_ON_BIT = 7;
    localparam int PRESCALE_MSB = 6;
    localparam int PRESCALE_LSB = 4;
    localparam int CLOCK_SELECT_MSB = 7;
    localparam int CLOCK_SELECT_LSB = 6;
    localparam int REFERENCE_MSB = 5;
    localparam int REFERENCE_LSB = 4;
    localparam int PIN_CONFIG_MSB = 3;
    localparam int PIN_CONFIG_LSB = 0;
    localparam int POLARITY_BIT = 0;
    localparam logic [7:0] POWER_RATE_WRITE_MASK = 8'hf0;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam int AUTO_BASE_COUNT = 1024;
    localparam int PRESCALE_WIDTH = 22;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b10
    } seq_state_t;

    typedef enum logic [1:0] {
        KIND_NONE = 2'b00,
        KIND_AUTO = 2'b01,
        KIND_ALL = 2'b10,
        KIND_SINGLE = 2'b11
    } seq_kind_t;

endpackage : analog_seq_pkg

/* testbench/converter_core_model.sv */
// Behavioural converter core that answers start pulses after a fixed delay.
`timescale 1ns/10ps
`default_nettype none
module converter_core_model #(
    parameter int LATENCY = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Start request and the analog value of each channel
    input wire logic convStart,
    input wire logic [1:0] convChannel,
    input wire logic [39:0] sampleValues,
    // Answer
    output logic convDone,
    output logic [9:0] convResult
);
    int remain;
    logic [1:0] chan;

    // The result bus is not held past the done pulse, so a late sampler sees a changing value.
    always @(posedge clk)
    begin
        convDone <= 1'b0;
        convResult <= ~convResult;
        if (reset)
        begin
            remain = 0;
            convResult <= 10'h000;
        end
        else if (convStart)
        begin
            remain = LATENCY;
            chan = convChannel;
        end
        else if (remain > 0)
        begin
            remain = remain - 1;
            if (remain == 0)
            begin
                convDone <= 1'b1;
                convResult <= sampleValues[chan * 10 +: 10];
            end
        end
    end
endmodule : converter_core_model
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the analog sample sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int SH[8] = '{0, 3, 5, 7, 9, 10, 11, 12};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic regWrEn = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRdEn = 1'b0;
    logic readAllReq = 1'b0;
    logic autoModeEnable = 1'b0;
    logic [39:0] sampleValues = 40'h0;
    logic [7:0] regRdData;
    logic regRdValid, readAllDone, changeMsgReq, converterPowerOn, convStart, convDone;
    logic [1:0] conversionClockSelect, referenceSelect, convChannel;
    logic [3:0] pinAnalogSelect;
    logic [9:0] convResult;
    logic [1:0] chanLog[$];
    int bad_count = 0;
    int checks = 0;
    int starts = 0;
    int msgs = 0;
    int cycle = 0;
    int lastStart = 0;
    int period = 0;

    analog_sample_sequencer #(.AUTO_BASE_CYCLES(4)) analog_sample_sequencer_inst (.clk(clk), .reset(reset),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .readAllReq(readAllReq), .readAllDone(readAllDone),
        .autoModeEnable(autoModeEnable), .changeMsgReq(changeMsgReq), .converterPowerOn(converterPowerOn),
        .conversionClockSelect(conversionClockSelect), .referenceSelect(referenceSelect),
        .pinAnalogSelect(pinAnalogSelect), .convStart(convStart), .convChannel(convChannel),
        .convDone(convDone), .convResult(convResult));
    converter_core_model converter_core_model_inst (.clk(clk), .reset(reset), .convStart(convStart),
        .convChannel(convChannel), .sampleValues(sampleValues), .convDone(convDone), .convResult(convResult));

    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycle <= cycle + 1;
        if (convStart === 1'b1)
        begin
            starts <= starts + 1;
            chanLog.push_back(convChannel);
            if (convChannel === 2'd0)
            begin
                period <= cycle - lastStart;
                lastStart <= cycle;
            end
        end
        if (changeMsgReq === 1'b1)
            msgs <= msgs + 1;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
        @(negedge clk);
    endtask : wr
    // Reads wait on the answer pulse, since an upper result read runs a conversion first.
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        while (regRdValid !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk($sformatf("register %h", a), exp, (n < 200) ? regRdData : 8'hxx);
    endtask : rc
    task automatic waitZero();
        int t;
        int n;
        t = lastStart;
        n = 0;
        while (lastStart == t && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        chk("channel zero start", 1'b1, n < 5000);
    endtask : waitZero
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    // The whole run takes about 21,000 cycles; 40,000 leaves ample margin.
    initial
    begin
        #400000;
        bad_count++;
        summarize();
    end

    initial
    begin
        logic [1:0] c;
        logic [7:0] up;
        logic [7:0] pol;
        int n;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        rc(8'h0e, 8'h00);
        rc(8'h0f, 8'h00);
        rc(8'h00, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 4; i++)
        begin
            c = i[1:0];
            wr(8'h0f, {c, c, c, c});
            chk("clock select", c, conversionClockSelect);
            chk("reference select", c, referenceSelect);
            chk("pin select", {c, c}, pinAnalogSelect);
        end
        wr(8'h0e, 8'hff);
        rc(8'h0e, 8'hf0);
        chk("power on", 1'b1, converterPowerOn);
        wr(8'h0e, 8'h00);
        wr(8'h33, 8'hff);
        rc(8'h33, 8'hc1);
        wr(8'h32, 8'ha5);
        rc(8'h32, 8'ha5);
        $display("test control fields done");
        // Powered off, an upper result read answers at once with no conversion.
        wr(8'h0f, 8'h00);
        wr(8'h50, 8'hff);
        rc(analog_seq_pkg::ADDR_RESULT_BASE, 8'h00);
        chk("starts while off", 0, starts);
        wr(8'h0e, 8'h80);
        sampleValues = {10'h3ff, 10'h2d5, 10'h0c6, 10'h100};
        rc(8'h54, 8'hb5);
        chk("starts after upper read", 1, starts);
        sampleValues[29:20] = 10'h000;
        rc(8'h55, 8'h40);
        chk("starts after lower read", 1, starts);
        $display("test single read done");
        wr(8'h0f, 8'h05);
        chanLog.delete();
        @(negedge clk);
        readAllReq = 1'b1;
        @(negedge clk);
        readAllReq = 1'b0;
        n = 0;
        while (readAllDone !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk("read-all done", 1'b1, readAllDone);
        chk("read-all channels", 2, chanLog.size());
        chk("read-all first", 2'd1, chanLog[0]);
        chk("read-all second", 2'd3, chanLog[1]);
        rc(8'h53, 8'h80);
        rc(8'h57, 8'hc0);
        $display("test read-all done");
        wr(8'h0f, 8'h00);
        wr(8'h00, 8'h01);
        autoModeEnable = 1'b1;
        for (int k = 1; k < 6; k++)
        begin
            wr(8'h0e, 8'h80 | (k[7:0] << 4));
            waitZero();
            waitZero();
            waitZero();
            chk("auto interval", 16'd4 << SH[k], period[15:0]);
        end
        $display("test auto interval done");
        sampleValues = {10'h3ff, 10'h2d5, 10'h100, 10'h100};
        wr(8'h0e, 8'h90);
        wr(8'h00, 8'h03);
        for (int e = 0; e < 4; e++)
        begin
            up = (e == 0 || e == 1) ? 8'h80 : ((e == 2) ? 8'h10 : 8'h40);
            pol = (e == 1 || e == 2) ? 8'h01 : 8'h00;
            wr(8'h32, up);
            wr(8'h33, pol);
            wr(8'h30, up);
            wr(8'h31, pol);
            waitZero();
            waitZero();
            msgs = 0;
            waitZero();
            chk("change messages", (e == 0 || e == 2) ? 1 : 0, msgs);
        end
        $display("test threshold done");
        autoModeEnable = 1'b0;
        repeat (20) @(negedge clk);
        wr(8'h00, 8'h01);
        wr(8'h0f, 8'h01);
        autoModeEnable = 1'b1;
        repeat (10) @(negedge clk);
        n = starts;
        repeat (300) @(negedge clk);
        chk("starts with timer idle", n, starts);
        $display("test timer gating done");
        summarize();
    end
endmodule : tb
`default_nettype wire
